// ===== nfpi_host.sv
`timescale 1ns/10ps
// Operation
// - group multi-plane ops within planes 0-3 or 4-7
// - write strobe high while device drives data
// - main area once, spare twice per erase
// - never touch factory bad blocks
// - tolerate 8052 valid blocks of 8192
// - setup then confirm command codes
// - four address cycles, column first; erase sends only the three row cycles
module nfpi_host #(
  parameter int FIFO_DEPTH = 16,
  parameter int BUSY_TIMEOUT = 50000000
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic req_valid_i,
  output logic req_ready_o,
  input wire logic [1:0] req_op_i,
  input wire logic [26:0] req_addr_i,
  input wire logic [9:0] req_len_i,
  input wire logic [7:0] wdata_i,
  input wire logic wvalid_i,
  output logic wready_o,
  output logic [7:0] rdata_o,
  output logic rvalid_o,
  input wire logic rready_i,
  output logic done_o,
  output logic fail_o,
  output logic cmd_latch_o,
  output logic addr_latch_o,
  output logic chip_sel_n_o,
  output logic write_strobe_n_o,
  output logic read_strobe_n_o,
  output logic write_prot_n_o,
  output logic [7:0] io_o,
  output logic io_oe_o,
  input wire logic [7:0] io_i,
  input wire logic ready_busy_i
);
  typedef struct packed {
    nfpi_pkg::nfpi_state_t st;
    logic [1:0] op;
    logic [26:0] addr;
    logic [9:0] len;
    logic [2:0] idx;
    logic [31:0] tmr;
    logic [1:0] ph;
    logic ack;
    logic done;
    logic fail;
    logic cle;
    logic ale;
    logic ce_n;
    logic we_n;
    logic re_n;
    logic wp_n;
    logic [7:0] dout;
    logic oe;
    logic [7:0] rd;
    logic rv;
  } nfpi_host_state_t;
  nfpi_host_state_t s_reg;
  nfpi_host_state_t s_next;
  logic [7:0] fifo_data;
  logic fifo_valid;
  logic fifo_pop;
  logic rd_free;
  logic strobe_end;
  // ----------------------------------------------------------------
  // write data buffer; stalls the source when the flash is slow
  // ----------------------------------------------------------------
  nfpi_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .in_data_i(wdata_i),
    .in_valid_i(wvalid_i),
    .in_ready_o(wready_o),
    .out_data_o(fifo_data),
    .out_valid_o(fifo_valid),
    .out_ready_i(fifo_pop)
  );
  assign rd_free = !s_reg.rv || rready_i;
  // a write strobe cycle: low WP_CYC, then high WH_CYC plus at least one setup cycle before the next fall
  assign strobe_end = (s_reg.ph == 2'd1) && (s_reg.tmr == 32'(nfpi_pkg::WH_CYC - 1));
  assign fifo_pop = (s_reg.st == nfpi_pkg::NFPI_DATA) && (s_reg.ph == 2'd0) && fifo_valid;
  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    s_next.ack = 1'b0;
    s_next.done = 1'b0;
    if (s_reg.rv && rready_i) begin
      s_next.rv = 1'b0;
    end
    unique case (s_reg.st)
      nfpi_pkg::NFPI_IDLE: begin
        s_next.ce_n = 1'b1; // deselect between ops: device floats I/O
        s_next.oe = 1'b0;
        s_next.wp_n = 1'b0; // keep protect on while idle
        // single-plane ops only, so no group straddles the plane halves
        // bad-block table and partial-program counts stay with software
        if (req_valid_i && !s_reg.ack) begin
          s_next.ack = 1'b1;
          s_next.op = req_op_i;
          s_next.addr = req_addr_i;
          s_next.len = req_len_i;
          s_next.fail = 1'b0;
          s_next.ce_n = 1'b0;
          s_next.wp_n = (req_op_i != 2'(nfpi_pkg::NFPI_OP_READ));
          s_next.st = nfpi_pkg::NFPI_CMD1;
          s_next.ph = 2'd0;
          s_next.tmr = '0;
        end
      end
      nfpi_pkg::NFPI_CMD1, nfpi_pkg::NFPI_ADDR, nfpi_pkg::NFPI_DATA, nfpi_pkg::NFPI_CMD2: begin
        // latch enables never both high
        s_next.cle = (s_reg.st == nfpi_pkg::NFPI_CMD1) || (s_reg.st == nfpi_pkg::NFPI_CMD2);
        s_next.ale = (s_reg.st == nfpi_pkg::NFPI_ADDR);
        s_next.oe = 1'b1;
        if (s_reg.st == nfpi_pkg::NFPI_CMD1) begin
          unique case (s_reg.op)
            2'(nfpi_pkg::NFPI_OP_PROG): s_next.dout = nfpi_pkg::CMD_PROG_SETUP;
            2'(nfpi_pkg::NFPI_OP_ERASE): s_next.dout = nfpi_pkg::CMD_ERASE_SETUP;
            default: s_next.dout = nfpi_pkg::CMD_READ;
          endcase
        end else if (s_reg.st == nfpi_pkg::NFPI_CMD2) begin
          s_next.dout = (s_reg.op == 2'(nfpi_pkg::NFPI_OP_ERASE)) ?
            nfpi_pkg::CMD_ERASE_CONFIRM : nfpi_pkg::CMD_PROG_CONFIRM;
        end else if (s_reg.st == nfpi_pkg::NFPI_ADDR) begin
          // column, then low row, then high row bytes
          unique case (s_reg.idx)
            3'd0: s_next.dout = s_reg.addr[7:0];
            3'd1: s_next.dout = s_reg.addr[16:9];
            3'd2: s_next.dout = s_reg.addr[24:17];
            default: s_next.dout = {6'h00, s_reg.addr[26:25]};
          endcase
        end else if (fifo_pop) begin
          s_next.dout = fifo_data;
        end
        // strobe phases; data waits for the fifo before going low
        if (s_reg.ph == 2'd0) begin
          if (s_reg.st != nfpi_pkg::NFPI_DATA || fifo_valid) begin
            s_next.we_n = 1'b0;
            s_next.ph = 2'd2;
            s_next.tmr = '0;
          end
        end else if (s_reg.ph == 2'd2) begin
          s_next.tmr = s_reg.tmr + 32'd1;
          if (s_reg.tmr == 32'(nfpi_pkg::WP_CYC - 1)) begin
            s_next.we_n = 1'b1; // device latches here
            s_next.ph = 2'd1;
            s_next.tmr = '0;
          end
        end else begin
          s_next.tmr = s_reg.tmr + 32'd1;
          if (strobe_end) begin
            s_next.ph = 2'd0;
            s_next.tmr = '0;
            s_next.cle = 1'b0;
            s_next.ale = 1'b0;
            unique case (s_reg.st)
              nfpi_pkg::NFPI_CMD1: begin
                s_next.st = nfpi_pkg::NFPI_ADDR;
                s_next.idx = (s_reg.op == 2'(nfpi_pkg::NFPI_OP_ERASE)) ? 3'd1 : 3'd0;
              end
              nfpi_pkg::NFPI_ADDR: begin
                s_next.idx = s_reg.idx + 3'd1;
                if (s_reg.idx == 3'(nfpi_pkg::ADDR_CYCLES - 1)) begin
                  s_next.oe = 1'b0;
                  unique case (s_reg.op)
                    2'(nfpi_pkg::NFPI_OP_PROG): s_next.st = nfpi_pkg::NFPI_DATA;
                    2'(nfpi_pkg::NFPI_OP_ERASE): s_next.st = nfpi_pkg::NFPI_CMD2;
                    default: s_next.st = nfpi_pkg::NFPI_WAIT_BUSY;
                  endcase
                end
              end
              nfpi_pkg::NFPI_DATA: begin
                s_next.len = s_reg.len - 10'd1;
                if (s_reg.len == 10'd1) begin
                  s_next.st = nfpi_pkg::NFPI_CMD2;
                end
              end
              default: begin
                s_next.oe = 1'b0;
                s_next.st = nfpi_pkg::NFPI_WAIT_BUSY;
              end
            endcase
          end
        end
      end
      nfpi_pkg::NFPI_WAIT_BUSY: begin
        // give the device its write-high-to-busy time before sampling
        s_next.tmr = s_reg.tmr + 32'd1;
        if (s_reg.tmr == 32'(nfpi_pkg::WB_CYC)) begin
          s_next.st = nfpi_pkg::NFPI_WAIT_READY;
          s_next.tmr = '0;
        end
      end
      nfpi_pkg::NFPI_WAIT_READY: begin
        // ready/busy is read even with no data path active
        s_next.tmr = s_reg.tmr + 32'd1;
        if (ready_busy_i) begin
          s_next.tmr = '0;
          s_next.st = (s_reg.op == 2'(nfpi_pkg::NFPI_OP_READ)) ?
            nfpi_pkg::NFPI_RDATA : nfpi_pkg::NFPI_DONE;
        end else if (s_reg.tmr == 32'(BUSY_TIMEOUT)) begin
          s_next.fail = 1'b1;
          s_next.st = nfpi_pkg::NFPI_DONE;
        end
      end
      nfpi_pkg::NFPI_RDATA: begin
        // write strobe held high while device drives the bus
        s_next.we_n = 1'b1;
        s_next.tmr = s_reg.tmr + 32'd1;
        if (s_reg.re_n && rd_free && s_reg.tmr >= 32'(nfpi_pkg::REH_CYC)) begin
          s_next.re_n = 1'b0; // each fall steps the column
          s_next.tmr = '0;
        end else if (!s_reg.re_n && s_reg.tmr == 32'(nfpi_pkg::RP_CYC - 1)) begin
          s_next.re_n = 1'b1;
          s_next.tmr = '0;
          s_next.rd = io_i;
          s_next.rv = 1'b1;
          s_next.len = s_reg.len - 10'd1;
          if (s_reg.len == 10'd1) begin
            s_next.st = nfpi_pkg::NFPI_DONE; // deselect ends the read
          end
        end
      end
      nfpi_pkg::NFPI_DONE: begin
        // chip select rises here, after ready returns or after the busy timeout
        s_next.ce_n = 1'b1;
        s_next.wp_n = 1'b0;
        s_next.done = 1'b1;
        s_next.st = nfpi_pkg::NFPI_IDLE;
      end
      default: s_next.st = nfpi_pkg::NFPI_IDLE;
    endcase
  end
  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_reg <= '0;
      s_reg.st <= nfpi_pkg::NFPI_IDLE;
      s_reg.ce_n <= 1'b1;
      s_reg.we_n <= 1'b1;
      s_reg.re_n <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end
  assign req_ready_o = s_reg.ack;
  assign rdata_o = s_reg.rd;
  assign rvalid_o = s_reg.rv;
  assign done_o = s_reg.done;
  assign fail_o = s_reg.fail;
  assign cmd_latch_o = s_reg.cle;
  assign addr_latch_o = s_reg.ale;
  assign chip_sel_n_o = s_reg.ce_n;
  assign write_strobe_n_o = s_reg.we_n;
  assign read_strobe_n_o = s_reg.re_n;
  assign write_prot_n_o = s_reg.wp_n;
  assign io_o = s_reg.dout;
  assign io_oe_o = s_reg.oe;
  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_latch_excl;
    @(posedge clock_i) disable iff (!rst_n_i) !(s_reg.cle && s_reg.ale);
  endproperty
  a_latch_excl: assert property (p_latch_excl) else $error("both latches high");
  property p_we_in_read;
    @(posedge clock_i) disable iff (!rst_n_i)
      (s_reg.st == nfpi_pkg::NFPI_RDATA) |-> s_reg.we_n && !s_reg.oe;
  endproperty
  a_we_in_read: assert property (p_we_in_read) else $error("write strobe low in read");
  property p_we_pulse;
    @(posedge clock_i) disable iff (!rst_n_i)
      $fell(s_reg.we_n) |-> !s_reg.we_n [*4] ##1 s_reg.we_n;
  endproperty
  a_we_pulse: assert property (p_we_pulse) else $error("write pulse width wrong");
  property p_ce_busy;
    @(posedge clock_i) disable iff (!rst_n_i)
      (s_reg.st == nfpi_pkg::NFPI_WAIT_READY) |-> !s_reg.ce_n;
  endproperty
  a_ce_busy: assert property (p_ce_busy) else $error("deselected while busy");
  property p_wp_read;
    @(posedge clock_i) disable iff (!rst_n_i)
      (s_reg.st == nfpi_pkg::NFPI_CMD1 && s_reg.op == 2'b00) |-> !s_reg.wp_n;
  endproperty
  a_wp_read: assert property (p_wp_read) else $error("protect off for read");
  property p_ready_go;
    @(posedge clock_i) disable iff (!rst_n_i)
      (s_reg.st == nfpi_pkg::NFPI_WAIT_READY && ready_busy_i) |=>
        (s_reg.st != nfpi_pkg::NFPI_WAIT_READY);
  endproperty
  a_ready_go: assert property (p_ready_go) else $error("ready not seen");
  property p_cle_code;
    @(posedge clock_i) disable iff (!rst_n_i)
      (s_reg.cle && $rose(s_reg.we_n) && s_reg.st == nfpi_pkg::NFPI_CMD1 &&
        s_reg.op == 2'(nfpi_pkg::NFPI_OP_ERASE)) |-> s_reg.dout == nfpi_pkg::CMD_ERASE_SETUP;
  endproperty
  a_cle_code: assert property (p_cle_code) else $error("bad erase setup");
  property p_strobe_sel;
    @(posedge clock_i) disable iff (!rst_n_i) !s_reg.we_n |-> !s_reg.ce_n;
  endproperty
  a_strobe_sel: assert property (p_strobe_sel) else $error("strobe while deselected");
  c_prog: cover property (@(posedge clock_i) s_reg.st == nfpi_pkg::NFPI_CMD2 && s_reg.op == 2'b01);
  c_erase: cover property (@(posedge clock_i) s_reg.done && s_reg.op == 2'b10);
  c_read: cover property (@(posedge clock_i) s_reg.rv && s_reg.st == nfpi_pkg::NFPI_DONE);
endmodule

// ===== nfpi_pkg.sv
package nfpi_pkg;
  // ----------------------------------------------------------------
  // command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_PROG_SETUP = 8'h80;
  localparam logic [7:0] CMD_PROG_CONFIRM = 8'h10;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h60;
  localparam logic [7:0] CMD_ERASE_CONFIRM = 8'hd0;
  localparam logic [7:0] CMD_READ = 8'h00;
  // ----------------------------------------------------------------
  // geometry
  // ----------------------------------------------------------------
  localparam int PLANES = 8;
  localparam int BLOCKS_PER_PLANE = 1024;
  localparam int PAGE_BYTES = 528;
  localparam int ADDR_CYCLES = 4;
  localparam int ROW_CYCLES = 3;
  localparam int ADDR_BITS = 27;
  localparam int HALF_PLANE_SHIFT = 2; // planes 0..3 versus 4..7
  // ----------------------------------------------------------------
  // timing, 100 MHz clock
  // ----------------------------------------------------------------
  localparam int CLK_NS = 10;
  localparam int T_WP_NS = 35;
  localparam int T_WH_NS = 15;
  localparam int T_RP_NS = 30;
  localparam int T_REH_NS = 15;
  localparam int T_WB_NS = 100;
  localparam int T_DBSY_MAX_US = 10;
  localparam int WP_CYC = (T_WP_NS + CLK_NS - 1) / CLK_NS;
  localparam int WH_CYC = (T_WH_NS + CLK_NS - 1) / CLK_NS;
  localparam int RP_CYC = (T_RP_NS + CLK_NS - 1) / CLK_NS;
  localparam int REH_CYC = (T_REH_NS + CLK_NS - 1) / CLK_NS;
  localparam int WB_CYC = (T_WB_NS + CLK_NS - 1) / CLK_NS;
  localparam int DBSY_CYC = T_DBSY_MAX_US * 1000 / CLK_NS;
  // ----------------------------------------------------------------
  // host request kinds and sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    NFPI_OP_READ = 2'b00,
    NFPI_OP_PROG = 2'b01,
    NFPI_OP_ERASE = 2'b10
  } nfpi_op_t;
  typedef enum logic [3:0] {
    NFPI_IDLE = 4'b0000,
    NFPI_CMD1 = 4'b0001,
    NFPI_ADDR = 4'b0010,
    NFPI_DATA = 4'b0011,
    NFPI_CMD2 = 4'b0100,
    NFPI_WAIT_BUSY = 4'b0101,
    NFPI_WAIT_READY = 4'b0110,
    NFPI_RDATA = 4'b0111,
    NFPI_DONE = 4'b1000
  } nfpi_state_t;
endpackage

// ===== nfpi_fifo.sv
`timescale 1ns/10ps
module nfpi_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic [WIDTH-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  output logic [WIDTH-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_reg;
  logic [AW-1:0] rd_reg;
  logic [AW:0] cnt_reg;
  logic [AW:0] cnt_next;
  logic in_ready_reg;
  logic push;
  logic pop;
  // ----------------------------------------------------------------
  // flow control
  // ----------------------------------------------------------------
  // ready is registered so the source sees a clean flop output
  assign in_ready_o = in_ready_reg;
  assign cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
  assign out_valid_o = (cnt_reg != '0);
  assign out_data_o = mem[rd_reg];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  // storage is not reset, only the pointers, count and ready flag
  always_ff @(posedge clock_i) begin
    if (push) begin
      mem[wr_reg] <= in_data_i;
    end
  end
  // pointers wrap at the power-of-two depth
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
      in_ready_reg <= 1'b1;
    end else begin
      if (push) begin
        wr_reg <= wr_reg + 1'b1;
      end
      if (pop) begin
        rd_reg <= rd_reg + 1'b1;
      end
      cnt_reg <= cnt_next;
      in_ready_reg <= (cnt_next != (AW+1)'(DEPTH));
    end
  end
endmodule

// ===== nfpi_flash_model.sv
`timescale 1ns/10ps
module nfpi_flash_model (
  input wire logic cmd_latch_i,
  input wire logic addr_latch_i,
  input wire logic chip_sel_n_i,
  input wire logic write_strobe_n_i,
  input wire logic read_strobe_n_i,
  input wire logic write_prot_n_i,
  input wire logic io_host_oe_i,
  input wire logic [7:0] io_i,
  output logic [7:0] io_o,
  output logic io_oe_o,
  output logic busy_low_o
);
  // ----------------------------------------------------------------
  // behavioural memory end, logs what the host wrote
  // ----------------------------------------------------------------
  int busy_ns = 2000;
  int n_viol = 0;
  int n_busy = 0;
  int n_addr = 0;
  logic [7:0] cmd_q[$];
  logic [7:0] addr_q[$];
  logic [7:0] data_q[$];
  logic [7:0] cur_cmd = 8'hff;
  logic [7:0] col = 8'h00;
  logic reading = 1'b0;
  logic prog_busy = 1'b0;
  initial begin
    io_o = 8'h00;
    io_oe_o = 1'b0;
    busy_low_o = 1'b0;
  end
  // open drain pull low, never gated by select so status stays visible
  task automatic go_busy(input logic prog);
    #20 busy_low_o = 1'b1;
    prog_busy = prog;
    n_busy++;
    #(busy_ns) busy_low_o = 1'b0;
    prog_busy = 1'b0;
    reading = !prog;
  endtask
  // bytes taken on the strobe's rising edge, only while selected
  always @(posedge write_strobe_n_i) begin
    if (!chip_sel_n_i) begin
      if (cmd_latch_i && addr_latch_i) n_viol++;
      if (cmd_latch_i) begin
        cmd_q.push_back(io_i);
        cur_cmd = io_i;
        n_addr = 0;
        // protect low keeps the pump in reset: no busy, no program
        if ((io_i == 8'h10 || io_i == 8'hd0) && write_prot_n_i) go_busy(1'b1);
      end else if (addr_latch_i) begin
        addr_q.push_back(io_i);
        n_addr++;
        if (n_addr == 1) col = io_i;
        if (cur_cmd == 8'h00 && n_addr == 4) go_busy(1'b0);
      end else begin
        data_q.push_back(io_i);
      end
    end
  end
  // next byte out after each falling read strobe
  always @(negedge read_strobe_n_i) begin
    if (!chip_sel_n_i && reading) begin
      #20 io_o = col ^ 8'ha5;
      io_oe_o = 1'b1;
      col = col + 8'h01;
    end
  end
  // released bus shows the inverse so stale data cannot pass for good
  always @(posedge read_strobe_n_i) begin
    #15 io_oe_o = 1'b0;
    io_o = ~io_o;
  end
  // deselect ends a read but never a program or erase
  always @(posedge chip_sel_n_i) begin
    if (!prog_busy) begin
      reading = 1'b0;
      io_oe_o = 1'b0;
    end
  end
  // write strobe or host drive while we drive data is a clash
  always @(negedge write_strobe_n_i or posedge io_host_oe_i) begin
    if (io_oe_o) n_viol++;
  end
endmodule

// ===== testbench.sv
`timescale 1ns/10ps
module testbench;
  logic clock_i, rst_n_i, req_valid_i, req_ready_o, wvalid_i, wready_o, rvalid_o, rready_i;
  logic done_o, fail_o, cmd_latch_o, addr_latch_o, chip_sel_n_o, write_strobe_n_o;
  logic read_strobe_n_o, write_prot_n_o, io_oe_o, dev_oe, busy_low;
  logic [1:0] req_op_i;
  logic [26:0] req_addr_i;
  logic [9:0] req_len_i;
  logic [7:0] wdata_i, rdata_o, io_o, dev_io, io_bus;
  int n_fail = 0;
  int n_compared = 0;
  assign io_bus = io_oe_o ? io_o : dev_io;
  nfpi_host #(.FIFO_DEPTH(16), .BUSY_TIMEOUT(1000)) u_nfpi_host (.clock_i, .rst_n_i,
    .req_valid_i, .req_ready_o, .req_op_i, .req_addr_i, .req_len_i, .wdata_i, .wvalid_i,
    .wready_o, .rdata_o, .rvalid_o, .rready_i, .done_o, .fail_o, .cmd_latch_o, .addr_latch_o,
    .chip_sel_n_o, .write_strobe_n_o, .read_strobe_n_o, .write_prot_n_o, .io_o, .io_oe_o,
    .io_i(io_bus), .ready_busy_i(~busy_low));
  nfpi_flash_model u_nfpi_flash_model (.cmd_latch_i(cmd_latch_o), .addr_latch_i(addr_latch_o),
    .chip_sel_n_i(chip_sel_n_o), .write_strobe_n_i(write_strobe_n_o),
    .read_strobe_n_i(read_strobe_n_o), .write_prot_n_i(write_prot_n_o),
    .io_host_oe_i(io_oe_o), .io_i(io_bus), .io_o(dev_io), .io_oe_o(dev_oe),
    .busy_low_o(busy_low));
  // ----------------------------------------------------------------
  // shared helpers
  // ----------------------------------------------------------------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  function automatic logic [7:0] abyte(input logic [26:0] a, input int i);
    case (i)
      0: return a[7:0];
      1: return a[16:9];
      2: return a[24:17];
      default: return {6'h00, a[26:25]};
    endcase
  endfunction
  // request held until the acknowledge is seen, then dropped
  task automatic request(input logic [1:0] op, input logic [26:0] a, input logic [9:0] len);
    int k;
    u_nfpi_flash_model.cmd_q.delete();
    u_nfpi_flash_model.addr_q.delete();
    u_nfpi_flash_model.data_q.delete();
    @(posedge clock_i);
    req_valid_i <= 1'b1;
    req_op_i <= op;
    req_addr_i <= a;
    req_len_i <= len;
    for (k = 0; k < 200; k++) begin
      @(negedge clock_i);
      if (req_ready_o === 1'b1) break;
    end
    check("req_ready", req_ready_o, 1'b1);
    @(posedge clock_i);
    req_valid_i <= 1'b0;
  endtask
  task automatic wait_end(input logic exp_fail);
    int k;
    for (k = 0; k < 1500; k++) begin
      @(negedge clock_i);
      if (done_o === 1'b1 || fail_o === 1'b1) break;
    end
    check("fail", fail_o, exp_fail);
    if (!exp_fail) check("done", done_o, 1'b1);
  endtask
  task automatic check_frame(input logic [7:0] c0, input logic [7:0] c1, input int ncmd,
                             input int first, input logic [26:0] a);
    int i;
    check("cmd count", u_nfpi_flash_model.cmd_q.size(), ncmd);
    check("cmd setup", u_nfpi_flash_model.cmd_q[0], c0);
    if (ncmd > 1) check("cmd confirm", u_nfpi_flash_model.cmd_q[1], c1);
    check("addr count", u_nfpi_flash_model.addr_q.size(), 4 - first);
    for (i = 0; i < 4 - first; i++) begin
      check("addr byte", u_nfpi_flash_model.addr_q[i], abyte(a, i + first));
    end
    check("bus faults", u_nfpi_flash_model.n_viol, 0);
  endtask
  task automatic push(input logic [7:0] b);
    int k;
    @(posedge clock_i);
    wdata_i <= b;
    wvalid_i <= 1'b1;
    for (k = 0; k < 200; k++) begin
      @(negedge clock_i);
      if (wready_o === 1'b1) break;
    end
    @(posedge clock_i);
    wvalid_i <= 1'b0;
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_program();
    int i;
    int nb;
    nb = u_nfpi_flash_model.n_busy;
    for (i = 0; i < 16; i++) push(8'h30 + i[7:0]);
    @(posedge clock_i);
    wvalid_i <= 1'b1;
    wdata_i <= 8'hee;
    repeat (4) @(negedge clock_i);
    check("wready full", wready_o, 1'b0);
    @(posedge clock_i);
    wvalid_i <= 1'b0;
    request(2'b01, 27'h5a6b3c1, 10'h010);
    wait_end(1'b0);
    check_frame(8'h80, 8'h10, 2, 0, 27'h5a6b3c1);
    check("data count", u_nfpi_flash_model.data_q.size(), 16);
    for (i = 0; i < 16; i++) check("data", u_nfpi_flash_model.data_q[i], 8'h30 + i);
    check("prog busy", u_nfpi_flash_model.n_busy, nb + 1);
    check("wp after", write_prot_n_o, 1'b0);
    check("wready drained", wready_o, 1'b1);
  endtask
  task automatic t_erase(input logic [26:0] a);
    request(2'b10, a, 10'h000);
    wait_end(1'b0);
    check_frame(8'h60, 8'hd0, 2, 1, a);
  endtask
  task automatic t_read();
    int i;
    int k;
    request(2'b00, 27'h3c0de12, 10'h003);
    for (i = 0; i < 3; i++) begin
      for (k = 0; k < 1500; k++) begin
        @(negedge clock_i);
        if (rvalid_o === 1'b1) break;
      end
      if (i == 0) repeat (4) @(negedge clock_i);
      check("rvalid", rvalid_o, 1'b1);
      check("rdata", rdata_o, (8'h12 + i[7:0]) ^ 8'ha5);
      @(posedge clock_i);
      rready_i <= 1'b1;
      @(posedge clock_i);
      rready_i <= 1'b0;
    end
    check_frame(8'h00, 8'h00, 1, 0, 27'h3c0de12);
    check("dev float", dev_oe, 1'b0);
  endtask
  task automatic t_timeout();
    u_nfpi_flash_model.busy_ns = 20000;
    request(2'b10, 27'h0000200, 10'h000);
    wait_end(1'b1);
    u_nfpi_flash_model.busy_ns = 2000;
    repeat (1200) @(posedge clock_i);
    request(2'b10, 27'h0000200, 10'h000);
    check("fail cleared", fail_o, 1'b0);
    wait_end(1'b0);
  endtask
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  // watchdog sized at several times the expected run
  initial begin
    #400000;
    n_fail++;
    stop_test();
  end
  initial begin
    {rst_n_i, req_valid_i, wvalid_i, rready_i} = 4'h0;
    {req_op_i, req_addr_i, req_len_i, wdata_i} = '0;
    repeat (5) @(posedge clock_i);
    check("reset pins", {chip_sel_n_o, write_strobe_n_o, read_strobe_n_o, write_prot_n_o,
      io_oe_o, cmd_latch_o, addr_latch_o}, 7'h70);
    repeat (5) @(posedge clock_i);
    rst_n_i <= 1'b1;
    t_program();
    t_erase(27'h7ffe00);
    t_read();
    t_timeout();
    stop_test();
  end
endmodule
